// ===== verification/accessory_model.sv
// Purpose: accessory on the connector plus the ID converter it is measured by
// Assumes: plugged, code, tiny and lat set by the bench
// Notes: converter output is a live level, ready is a one-cycle pulse
`include "usb_acc_defs.vh"
`default_nettype none
module accessory_model (
   input wire logic       ref_clk, sys_rst, plugged, tiny, id_adc_enable_ff,
   input wire logic [4:0] code,
   input wire logic [3:0] lat,
   output logic           id_below_1m, id_below_2k, id_adc_ready,
   output logic     [4:0] id_adc_value
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt_ff;
   assign id_below_1m = plugged;
   assign id_below_2k = plugged & tiny;
   // Open ID line reads full scale, so a stale code never shows
   assign id_adc_value = plugged ? code : `ADC_FULL;
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_ff <= 4'h0;
         id_adc_ready <= 1'b0;
      end else if (!id_adc_enable_ff || cnt_ff > lat) begin
         id_adc_ready <= 1'b0;
         if (!id_adc_enable_ff) cnt_ff <= 4'h0;
      end else begin
         id_adc_ready <= (cnt_ff == lat);
         cnt_ff <= cnt_ff + 4'h1;
      end
   end
endmodule // accessory_model
`default_nettype wire

// ===== verification/tb.sv
// Purpose: self-checking bench for the OTG switch and accessory ID block
// Assumes: stuck-key time shortened to STUCK cycles
// Notes: inputs change on the falling edge only
`include "usb_acc_defs.vh"
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam integer STUCK = 20;
   localparam logic [2:0] SW [4] = '{3'h4, 3'h2, 3'h0, 3'h3};
   logic ref_clk = 1'b0, sys_rst = 1'b1, system_reset_n = 1'b1, vbus_valid = 1'b1;
   logic vbus_overvoltage = 1'b0, phy_reg_source_select = 1'b0, otg_drive_enable = 1'b0;
   logic boost_enable = 1'b0, phy_regulator_enable_wr = 1'b0, phy_regulator_enable_wdata = 1'b0;
   logic flags_clear = 1'b0, plugged = 1'b0, tiny = 1'b0;
   logic [3:0] power_up_mode_straps = 4'h0, lat = 4'h2;
   logic [4:0] code = 5'h00;
   wire id_below_1m, id_below_2k, id_adc_ready, phy_regulator_enable_ff, phy_regulator_on_ff;
   wire host_supply_switch_ff, boost_supply_switch_ff, otg_bus_switch_ff, charger_input_switch_ff;
   wire charger_isolation_switch_ff, boost_on_ff, usb_detect_irq_ff, id_floating_flag_ff;
   wire id_adc_enable_ff, adc_done_flag_ff, id_detect_done_ff, active_mode_ff, attach_flag_ff;
   wire unknown_attach_flag_ff, detach_flag_ff, stuck_key_irq_ff, stuck_key_release_irq_ff;
   wire [4:0] id_adc_value, adc_result_ff;
   wire [1:0] device_type_ff;
   int mismatches = 0;
   int n_compared = 0;
   int i;
   usb_acc_otg_switch #(.STUCK_CYCLES(STUCK)) i_dut (.*);
   accessory_model i_acc (.*);
   always #20 ref_clk = ~ref_clk;
   task automatic step(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up;
      $display("compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic clr;
      flags_clear = 1'b1;
      step(1);
      flags_clear = 1'b0;
   endtask
   task automatic wait_done(input int lim);
      int k;
      for (k = 0; k < lim && id_detect_done_ff !== 1'b1; k++) step(1);
      if (k == lim) begin
         chk(8'h00, 8'h01);
         wrap_up();
      end
   endtask
   task automatic id_run(input logic [4:0] c, input logic t, input logic [7:0] res,
                         input logic [7:0] typ, input logic unk);
      clr();
      code = c;
      tiny = t;
      plugged = 1'b1;
      step(2);
      chk(id_adc_enable_ff, 1);
      chk(active_mode_ff, 1);
      wait_done(60);
      chk(id_floating_flag_ff, 0);
      chk(adc_result_ff, res);
      chk(adc_done_flag_ff, 1);
      chk(device_type_ff, typ);
      chk(unknown_attach_flag_ff, unk);
      chk(attach_flag_ff, !unk);
      plugged = 1'b0;
      step(3);
      chk(id_floating_flag_ff, 1);
      chk(detach_flag_ff, 1);
   endtask
   task automatic key_run(input int hold, input logic stuck);
      clr();
      code = 5'h05;
      tiny = 1'b0;
      plugged = 1'b1;
      step(hold);
      chk(stuck_key_irq_ff, stuck);
      code = 5'h10;
      wait_done(80);
      chk(stuck_key_release_irq_ff, stuck);
      chk(device_type_ff, `DT_SUPPORTED);
      plugged = 1'b0;
      step(3);
   endtask
   initial begin
      step(2);
      sys_rst = 1'b0;
      step(2);
      chk(phy_regulator_enable_ff, 1);
      chk(adc_result_ff, `ADC_FULL);
      chk(id_floating_flag_ff, 1);
      $display("test reset done");
      clr();
      for (i = 0; i < 4; i++) begin
         {otg_drive_enable, phy_reg_source_select} = i[1:0];
         step(2);
         chk({host_supply_switch_ff, boost_supply_switch_ff, otg_bus_switch_ff}, SW[i]);
      end
      for (i = 0; i < 2; i++) begin
         phy_regulator_enable_wdata = i[0];
         phy_regulator_enable_wr = 1'b1;
         step(1);
         phy_regulator_enable_wr = 1'b0;
         step(2);
         chk(phy_regulator_on_ff, i[0]);
      end
      phy_regulator_enable_wdata = 1'b0;
      chk({charger_input_switch_ff, charger_isolation_switch_ff}, 0);
      chk(usb_detect_irq_ff, 1);
      chk(boost_on_ff, 0);
      boost_enable = 1'b1;
      step(2);
      chk(boost_on_ff, 1);
      vbus_overvoltage = 1'b1;
      step(3);
      chk({host_supply_switch_ff, otg_bus_switch_ff, phy_regulator_on_ff}, 0);
      vbus_overvoltage = 1'b0;
      {otg_drive_enable, phy_reg_source_select} = 2'h0;
      $display("test switches done");
      step(3);
      chk(phy_regulator_on_ff, 1);
      for (i = 0; i < 2; i++) begin
         phy_regulator_enable_wr = 1'b1;
         step(1);
         phy_regulator_enable_wr = 1'b0;
         step(1);
         chk(phy_regulator_enable_ff, 0);
         if (i == 0) vbus_valid = 1'b0;
         else system_reset_n = 1'b0;
         step(3);
         chk(phy_regulator_enable_ff, 1);
         chk(phy_regulator_on_ff, i[0]);
         vbus_valid = 1'b1;
         system_reset_n = 1'b1;
         step(3);
         chk(phy_regulator_on_ff, 1);
      end
      $display("test regulator done");
      id_run(5'h10, 1'b0, 8'h10, `DT_SUPPORTED, 1'b0);
      lat = 4'h6;
      id_run(5'h1A, 1'b0, 8'h1A, `DT_UNSUPPORTED, 1'b0);
      lat = 4'h2;
      id_run(5'h1E, 1'b0, 8'h1E, `DT_NONE, 1'b1);
      id_run(5'h10, 1'b1, 8'h00, `DT_NONE, 1'b1);
      $display("test identification done");
      key_run(8, 1'b0);
      key_run(40, 1'b1);
      $display("test stuck key done");
      power_up_mode_straps = `STRAP_BOOST_MODE;
      vbus_valid = 1'b0;
      phy_reg_source_select = 1'b1;
      sys_rst = 1'b1;
      step(2);
      sys_rst = 1'b0;
      step(3);
      chk(phy_regulator_enable_ff, 1);
      chk(phy_regulator_on_ff, 1);
      chk({host_supply_switch_ff, boost_supply_switch_ff, otg_bus_switch_ff}, 3'h2);
      $display("test boost straps done");
      wrap_up();
   end
endmodule // tb
`default_nettype wire

// ===== verification/usb_acc_otg_switch_sva.sv
// Purpose: concurrent checks on the supply switches and the ID flow outputs
// Assumes: bound into usb_acc_otg_switch, one clock domain
// Notes: code ranges come from the design parameters, except the 5'h1D upper bound in AST_UNKNOWN
`include "usb_acc_defs.vh"
`default_nettype none
module usb_acc_chk #(
   parameter [4:0] KEY_LO = 5'h02,
   parameter [4:0] SUP_LO = 5'h0D,
   parameter [4:0] SUP_HI = 5'h18
) (
   input wire logic       ref_clk, sys_rst, system_reset_n, vbus_valid, vbus_overvoltage,
   input wire logic       phy_reg_source_select, otg_drive_enable, id_below_1m, id_below_2k,
   input wire logic       id_adc_ready, phy_regulator_enable_ff, phy_regulator_on_ff,
   input wire logic       host_supply_switch_ff, boost_supply_switch_ff, otg_bus_switch_ff,
   input wire logic       charger_input_switch_ff, charger_isolation_switch_ff,
   input wire logic       id_floating_flag_ff, id_adc_enable_ff, adc_done_flag_ff,
   input wire logic       id_detect_done_ff, active_mode_ff, attach_flag_ff,
   input wire logic       unknown_attach_flag_ff,
   input wire logic [3:0] power_up_mode_straps,
   input wire logic [4:0] id_adc_value, adc_result_ff,
   input wire logic [1:0] device_type_ff
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   sequence s_conv_end;
      id_adc_enable_ff && id_adc_ready ##1 adc_done_flag_ff && !id_adc_enable_ff;
   endsequence
   AST_HOST_FEED: assert property (!phy_reg_source_select && !otg_drive_enable && !vbus_overvoltage
      |=> host_supply_switch_ff && !boost_supply_switch_ff && !otg_bus_switch_ff)
      else $error("host feed switches wrong");
   AST_BOOST_FEED: assert property (phy_reg_source_select && !otg_drive_enable && !vbus_overvoltage
      |=> boost_supply_switch_ff && !host_supply_switch_ff && !otg_bus_switch_ff)
      else $error("boost feed switches wrong");
   AST_OTG_DRIVE: assert property (phy_reg_source_select && otg_drive_enable && !vbus_overvoltage
      |=> boost_supply_switch_ff && otg_bus_switch_ff && !host_supply_switch_ff
      && !charger_input_switch_ff && !charger_isolation_switch_ff)
      else $error("otg switches wrong");
   AST_OTG_OFF: assert property (!otg_drive_enable |=> !otg_bus_switch_ff)
      else $error("bus switch closed without otg");
   AST_OVERVOLT: assert property (vbus_overvoltage[*2] |-> !host_supply_switch_ff
      && !otg_bus_switch_ff && !phy_regulator_on_ff)
      else $error("over-voltage not handled");
   AST_NO_VBUS: assert property ((power_up_mode_straps != `STRAP_BOOST_MODE && !vbus_valid)[*2]
      |-> !phy_regulator_on_ff)
      else $error("regulator on without bus voltage");
   AST_EN_RELOAD: assert property (power_up_mode_straps != `STRAP_BOOST_MODE
      && (!system_reset_n || !vbus_valid) |=> phy_regulator_enable_ff)
      else $error("enable bit not reloaded");
   AST_ID_START: assert property ($rose(id_below_1m) && id_floating_flag_ff && !active_mode_ff
      |=> id_adc_enable_ff && active_mode_ff)
      else $error("identification did not start");
   AST_CONV_STORE: assert property (id_adc_enable_ff && id_adc_ready && id_below_1m && !id_below_2k
      |=> adc_done_flag_ff && !id_adc_enable_ff && adc_result_ff == $past(id_adc_value))
      else $error("conversion result not stored");
   AST_LOW_RES: assert property (id_adc_enable_ff && id_adc_ready && id_below_2k
      |=> adc_result_ff == `ADC_ZERO)
      else $error("low resistance result not forced");
   AST_SUPPORTED: assert property (s_conv_end ##0 (adc_result_ff >= SUP_LO && adc_result_ff <= SUP_HI)
      |=> id_detect_done_ff && attach_flag_ff && device_type_ff == `DT_SUPPORTED)
      else $error("supported accessory not reported");
   AST_UNKNOWN: assert property (s_conv_end ##0 (adc_result_ff > 5'h1D || adc_result_ff < KEY_LO)
      |=> id_detect_done_ff && unknown_attach_flag_ff)
      else $error("unknown accessory not reported");
endmodule // usb_acc_chk
bind usb_acc_otg_switch usb_acc_chk #(.KEY_LO(KEY_LO), .SUP_LO(SUP_LO), .SUP_HI(SUP_HI)) i_chk (.*);
`default_nettype wire

// ===== verilog/usb_acc_defs.vh
// Purpose: constants for the USB accessory identification and OTG switch block
// Assumes: 25 MHz ref_clk
// Notes: times in their own unit, cycle counts derived from them
`ifndef USB_ACC_DEFS_VH
`define USB_ACC_DEFS_VH
`define CLK_HZ            25000000
`define STRAP_BOOST_MODE  4'h4
`define ADC_ZERO          5'h00
`define ADC_FULL          5'h1F
`define STUCK_TIME_MS     1500
`define STUCK_CYCLES      ((`CLK_HZ / 1000) * `STUCK_TIME_MS)
`define ADC_TIME_US       10
`define ADC_CYCLES        ((`CLK_HZ / 1000000) * `ADC_TIME_US)
`define ST_IDLE           3'h0
`define ST_CONVERT        3'h1
`define ST_DECIDE         3'h2
`define ST_KEY_WAIT       3'h3
`define ST_KEY_STUCK      3'h4
`define ST_ATTACHED       3'h5
`define DT_NONE           2'h0
`define DT_SUPPORTED      2'h1
`define DT_UNSUPPORTED    2'h2
`endif

// ===== verilog/usb_acc_otg_switch.v
// Purpose: supply switch control for the USB PHY regulator, OTG bus drive, and the
//          accessory identification flow with stuck remote-key detection
// Assumes: all inputs synchronous to ref_clk; ID converter is external, started by
//          id_adc_enable and answering with id_adc_ready and id_adc_value
// Notes: code ranges for accessory classes are parameters
//
// Notes on behaviour
// - Source select 0 feeds the PHY regulator from VBUS via host supply switch.
// - Source select 1 feeds regulator from boost; bus drive only with OTG enable.
// - Select and OTG enable only close the bus path; boost enabled separately.
// - Straps 0100 default regulator on from boost, boost supply switch closed; here only with source select 1, select 0 still uses host switch.
// - Other straps: regulator cannot be enabled without VBUS present, except in OTG mode.
// - VBUS detected at cold start or later enables regulator fed from VBUS.
// - Regulator enable bit initialised to 1 for any straps, reloaded on reset or VBUS loss unless straps are 0100.
// - OTG with select: close boost and bus switches, open host and charger switches.
// - OTG disabled keeps the boost-to-bus switch open.
// - USB detect interrupt raised when boost drives VBUS in OTG mode.
// - Over-voltage disables regulator and opens host supply and OTG bus switches.
// - Attachment on ID, or VBUS rise with ID below 1 megohm, enters Active mode and starts identification.
// - On finish set device type bit and attach flag, else unknown attach flag.
// - Accessories sorted as supported, recognised unsupported, or unknown.
// - ID float flag reads 0 under 1 megohm to ground, 1 when removed.
// - Float fall starts identification, rise starts detach; done signal marks end.
// - Float fall asserts converter enable for a 5-bit ID conversion.
// - Conversion end sets done flag, stores result, clears converter enable.
// - Result forced 00000 below 2 kilohm and 11111 when Id_floating_flag.
// - Result matching an audio type 1 key starts the stuck key check.
// - Release within 1.5 s restarts ID; else stuck irq, then recovered irq.
`include "usb_acc_defs.vh"
`default_nettype none
module usb_acc_otg_switch #(
   parameter integer STUCK_CYCLES = `STUCK_CYCLES,
   parameter [4:0]   KEY_LO       = 5'h02,
   parameter [4:0]   KEY_HI       = 5'h0C,
   parameter [4:0]   SUP_LO       = 5'h0D,
   parameter [4:0]   SUP_HI       = 5'h18,
   parameter [4:0]   UNSUP_LO     = 5'h19,
   parameter [4:0]   UNSUP_HI     = 5'h1D
) (
   input  wire       ref_clk,
   input  wire       sys_rst,
   input  wire [3:0] power_up_mode_straps,
   input  wire       system_reset_n,
   input  wire       vbus_valid,
   input  wire       vbus_overvoltage,
   input  wire       phy_reg_source_select,
   input  wire       otg_drive_enable,
   input  wire       boost_enable,
   input  wire       phy_regulator_enable_wr,
   input  wire       phy_regulator_enable_wdata,
   input  wire       id_below_1m,
   input  wire       id_below_2k,
   input  wire       id_adc_ready,
   input  wire [4:0] id_adc_value,
   input  wire       flags_clear,
   output reg        phy_regulator_enable_ff,
   output reg        phy_regulator_on_ff,
   output reg        host_supply_switch_ff,
   output reg        boost_supply_switch_ff,
   output reg        otg_bus_switch_ff,
   output reg        charger_input_switch_ff,
   output reg        charger_isolation_switch_ff,
   output reg        boost_on_ff,
   output reg        usb_detect_irq_ff,
   output reg        id_floating_flag_ff,
   output reg        id_adc_enable_ff,
   output reg        adc_done_flag_ff,
   output reg  [4:0] adc_result_ff,
   output reg        id_detect_done_ff,
   output reg        active_mode_ff,
   output reg  [1:0] device_type_ff,
   output reg        attach_flag_ff,
   output reg        unknown_attach_flag_ff,
   output reg        detach_flag_ff,
   output reg        stuck_key_irq_ff,
   output reg        stuck_key_release_irq_ff
);

   function in_range;
      input [4:0] v;
      input [4:0] lo;
      input [4:0] hi;
      begin
         in_range = (v >= lo) && (v <= hi);
      end
   endfunction

   // Key codes count as a supported cable; anything outside every class is unknown
   function [1:0] code_class;
      input [4:0] v;
      begin
         if (in_range(v, SUP_LO, SUP_HI) || in_range(v, KEY_LO, KEY_HI))
            code_class = `DT_SUPPORTED;
         else if (in_range(v, UNSUP_LO, UNSUP_HI))
            code_class = `DT_UNSUPPORTED;
         else
            code_class = `DT_NONE;
      end
   endfunction

   // Sticky flag: a new event wins over a same-cycle clear
   function sticky;
      input cur;
      input clr;
      input evt;
      begin
         sticky = (cur & ~clr) | evt;
      end
   endfunction

   // Identification flow states
   localparam [2:0] S_IDLE      = `ST_IDLE;
   localparam [2:0] S_CONVERT   = `ST_CONVERT;
   localparam [2:0] S_DECIDE    = `ST_DECIDE;
   localparam [2:0] S_KEY_WAIT  = `ST_KEY_WAIT;
   localparam [2:0] S_KEY_STUCK = `ST_KEY_STUCK;
   localparam [2:0] S_ATTACHED  = `ST_ATTACHED;

   reg  [3:0]  strap_ff;
   reg         strap_taken_ff;
   reg         vbus_d_ff;
   reg  [2:0]  state_ff;
   reg  [2:0]  nxt_state;
   reg  [31:0] timer_ff;
   reg  [31:0] nxt_timer;
   reg  [4:0]  nxt_result;
   reg         nxt_adc_en;
   wire        boost_mode = (strap_ff == `STRAP_BOOST_MODE);
   wire        otg_mode   = phy_reg_source_select & otg_drive_enable;
   wire        float_fall = id_floating_flag_ff & id_below_1m;
   wire        float_rise = ~id_floating_flag_ff & ~id_below_1m;
   wire        vbus_rise  = vbus_valid & ~vbus_d_ff;
   // Forced codes override the raw converter word
   wire [4:0]  adc_word   = id_below_2k ? `ADC_ZERO :
                            (~id_below_1m ? `ADC_FULL : id_adc_value);

   // Straps caught once after reset release, never under the async reset
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         strap_ff       <= 4'h0;
         strap_taken_ff <= 1'b0;
         vbus_d_ff      <= 1'b0;
      end else begin
         vbus_d_ff <= vbus_valid;
         if (!strap_taken_ff) begin
            strap_ff       <= power_up_mode_straps;
            strap_taken_ff <= 1'b1;
         end
      end
   end

   // Regulator enable bit
   // Reload wins over a software write so the bit cannot stay off through reset or VBUS loss, except with straps 0100
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         phy_regulator_enable_ff <= 1'b0;
      end else if (!strap_taken_ff) begin
         phy_regulator_enable_ff <= 1'b1;
      end else if (!boost_mode && (!system_reset_n || !vbus_valid)) begin
         phy_regulator_enable_ff <= 1'b1;
      end else if (phy_regulator_enable_wr) begin
         phy_regulator_enable_ff <= phy_regulator_enable_wdata;
      end
   end

   // Supply switches; invalid select/OTG pair leaves host, boost and bus switches open, charger switches closed
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         phy_regulator_on_ff         <= 1'b0;
         host_supply_switch_ff       <= 1'b0;
         boost_supply_switch_ff      <= 1'b0;
         otg_bus_switch_ff           <= 1'b0;
         charger_input_switch_ff     <= 1'b0;
         charger_isolation_switch_ff <= 1'b0;
         boost_on_ff                 <= 1'b0;
         usb_detect_irq_ff           <= 1'b0;
      end else begin
         boost_on_ff <= boost_enable;
         // Boost drive on the bus looks like VBUS to detection logic
         usb_detect_irq_ff <= (usb_detect_irq_ff & ~flags_clear) | vbus_rise
                              | (otg_mode & ~otg_bus_switch_ff);
         if (vbus_overvoltage) begin
            phy_regulator_on_ff         <= 1'b0;
            host_supply_switch_ff       <= 1'b0;
            otg_bus_switch_ff           <= 1'b0;
            boost_supply_switch_ff      <= 1'b0;
            charger_input_switch_ff     <= 1'b0;
            charger_isolation_switch_ff <= 1'b0;
         end else if (otg_mode) begin
            phy_regulator_on_ff         <= phy_regulator_enable_ff;
            host_supply_switch_ff       <= 1'b0;
            boost_supply_switch_ff      <= 1'b1;
            otg_bus_switch_ff           <= 1'b1;
            charger_input_switch_ff     <= 1'b0;
            charger_isolation_switch_ff <= 1'b0;
         end else if (phy_reg_source_select && !otg_drive_enable) begin
            phy_regulator_on_ff         <= phy_regulator_enable_ff &
                                           (boost_mode | vbus_valid);
            host_supply_switch_ff       <= 1'b0;
            boost_supply_switch_ff      <= 1'b1;
            otg_bus_switch_ff           <= 1'b0;
            charger_input_switch_ff     <= 1'b1;
            charger_isolation_switch_ff <= 1'b1;
         end else if (!otg_drive_enable) begin
            phy_regulator_on_ff         <= phy_regulator_enable_ff & vbus_valid;
            host_supply_switch_ff       <= 1'b1;
            boost_supply_switch_ff      <= 1'b0;
            otg_bus_switch_ff           <= 1'b0;
            charger_input_switch_ff     <= 1'b1;
            charger_isolation_switch_ff <= 1'b1;
         end else begin
            // Invalid pair: nothing is fed rather than guess a route
            phy_regulator_on_ff         <= 1'b0;
            host_supply_switch_ff       <= 1'b0;
            boost_supply_switch_ff      <= 1'b0;
            otg_bus_switch_ff           <= 1'b0;
            charger_input_switch_ff     <= 1'b1;
            charger_isolation_switch_ff <= 1'b1;
         end
      end
   end

   // Identification flow
   always @* begin
      nxt_state  = state_ff;
      nxt_timer  = timer_ff;
      nxt_result = adc_result_ff;
      nxt_adc_en = id_adc_enable_ff;
      case (state_ff)
         S_IDLE: begin
            if (float_fall || (vbus_rise && id_below_1m)) begin
               nxt_state  = S_CONVERT;
               nxt_adc_en = 1'b1;
            end
         end
         S_CONVERT: begin
            if (id_adc_ready) begin
               nxt_result = adc_word;
               nxt_adc_en = 1'b0;
               nxt_state  = S_DECIDE;
            end
         end
         S_DECIDE: begin
            nxt_timer = 32'h0000_0000;
            if (in_range(adc_result_ff, KEY_LO, KEY_HI))
               nxt_state = S_KEY_WAIT;
            else
               nxt_state = S_ATTACHED;
         end
         S_KEY_WAIT: begin
            // Key release shows as a code change on re-measure, or as ID float
            if (!id_below_1m || (!id_below_2k && adc_word != adc_result_ff)) begin
               nxt_state  = S_CONVERT;
               nxt_adc_en = 1'b1;
            end else if (timer_ff >= STUCK_CYCLES - 1) begin
               nxt_state = S_KEY_STUCK;
            end else begin
               nxt_timer = timer_ff + 32'h0000_0001;
            end
         end
         S_KEY_STUCK: begin
            if (adc_word != adc_result_ff) begin
               nxt_state  = S_CONVERT;
               nxt_adc_en = 1'b1;
            end
         end
         S_ATTACHED: begin
            if (float_rise)
               nxt_state = S_IDLE;
         end
         default: nxt_state = S_IDLE;
      endcase
   end

   // One-cycle events that set the sticky flags
   wire       conv_end_evt  = (state_ff == S_CONVERT) && id_adc_ready;
   wire       decide_evt    = (state_ff == S_DECIDE);
   wire       detach_evt    = (state_ff == S_ATTACHED) && float_rise;
   // Key events look one state ahead so the flag rises with the move
   wire       key_stuck_evt = (state_ff == S_KEY_WAIT) && (nxt_state == S_KEY_STUCK);
   wire       key_free_evt  = (state_ff == S_KEY_STUCK) && (nxt_state == S_CONVERT);

   // Forced 00000 falls outside every class and so reports unknown
   wire [1:0] decide_class  = code_class(adc_result_ff);
   wire       decide_known  = (decide_class != `DT_NONE);

   // Flow state, converter handshake and live ID status
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_ff            <= S_IDLE;
         timer_ff            <= 32'h0000_0000;
         id_floating_flag_ff <= 1'b1;
         id_adc_enable_ff    <= 1'b0;
         adc_result_ff       <= `ADC_FULL;
         id_detect_done_ff   <= 1'b0;
         active_mode_ff      <= 1'b0;
      end else begin
         state_ff            <= nxt_state;
         timer_ff            <= nxt_timer;
         adc_result_ff       <= nxt_result;
         id_adc_enable_ff    <= nxt_adc_en;
         // Float flag trails the comparator by one cycle
         id_floating_flag_ff <= ~id_below_1m;
         // Tracks the next state so it rises together with the converter enable
         active_mode_ff      <= (nxt_state != S_IDLE);
         id_detect_done_ff   <= decide_evt;
      end
   end

   // Status flags, held until software clears them
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         adc_done_flag_ff         <= 1'b0;
         device_type_ff           <= `DT_NONE;
         attach_flag_ff           <= 1'b0;
         unknown_attach_flag_ff   <= 1'b0;
         detach_flag_ff           <= 1'b0;
         stuck_key_irq_ff         <= 1'b0;
         stuck_key_release_irq_ff <= 1'b0;
      end else begin
         adc_done_flag_ff         <= sticky(adc_done_flag_ff, flags_clear, conv_end_evt);
         attach_flag_ff           <= sticky(attach_flag_ff, flags_clear,
                                            decide_evt & decide_known);
         unknown_attach_flag_ff   <= sticky(unknown_attach_flag_ff, flags_clear,
                                            decide_evt & ~decide_known);
         detach_flag_ff           <= sticky(detach_flag_ff, flags_clear, detach_evt);
         stuck_key_irq_ff         <= sticky(stuck_key_irq_ff, flags_clear,
                                            key_stuck_evt);
         stuck_key_release_irq_ff <= sticky(stuck_key_release_irq_ff, flags_clear,
                                            key_free_evt);
         // Type stays valid while attached, cleared on detach
         if (decide_evt)
            device_type_ff <= decide_class;
         else if (detach_evt)
            device_type_ff <= `DT_NONE;
      end
   end

endmodule // usb_acc_otg_switch
`default_nettype wire
